// ==== design/bau_alu.sv ====
`timescale 1ns/1ps
// arithmetic/logic datapath with word ops and io bit read-modify-write
module bau_alu (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire bau_pkg::bau_op_t op,
    input  wire logic             op_valid,
    input  wire logic [7:0]       dest_operand_reg,
    input  wire logic [7:0]       source_operand_reg,
    input  wire logic             use_immediate,
    input  wire logic [7:0]       immediate_constant,
    input  wire logic [7:0]       pair_high_reg,
    input  wire logic [7:0]       pair_low_reg,
    input  wire logic [5:0]       flags_in,
    input  wire logic [5:0]       io_addr,
    input  wire logic [2:0]       io_bit,
    input  wire logic [7:0]       io_rdata,
    input  wire logic [7:0]       flag_hw_set,
    output logic      [7:0]       result,
    output logic                  result_we,
    output logic                  result_high,
    output logic      [5:0]       flags_out,
    output logic                  busy,
    output logic                  done,
    output logic                  io_rd,
    output logic                  io_we,
    output logic      [4:0]       io_wr_addr,
    output logic      [7:0]       io_wdata,
    output logic                  io_addr_error,
    output logic      [7:0]       wc_flags
);
    import bau_pkg::*;

    bau_state_s_t s_q;
    bau_state_s_t s_d;
    logic         err_q;
    logic         err_d;
    logic         wc_wr;
    logic [7:0]   wc_data;

    function automatic logic [7:0] sel_b(input logic imm, input logic [7:0] k,
                                         input logic [7:0] r);
        sel_b = imm ? k : r;
    endfunction : sel_b

    // local flag register: write-one-to-clear flags fed by io writes to address 0
    bau_flag_reg u_flags (
        .clk     (clk),
        .arst_n  (arst_n),
        .hw_set  (flag_hw_set),
        .wr_en   (wc_wr),
        .wr_data (wc_data),
        .flags_q (wc_flags)
    );

    always_comb begin
        logic [7:0]  a;
        logic [7:0]  b;
        logic        cin;
        logic [8:0]  sum;
        logic [4:0]  hsum;
        logic [7:0]  r;
        logic [16:0] w;
        logic [15:0] p;
        logic [7:0]  m;
        a    = dest_operand_reg;
        b    = sel_b(use_immediate, immediate_constant, source_operand_reg);
        cin  = 1'b0;
        sum  = 9'h000;
        hsum = 5'h00;
        r    = 8'h00;
        w    = 17'h00000;
        p    = {pair_high_reg, pair_low_reg};
        m    = 8'h00;
        s_d  = s_q;
        err_d = 1'b0;
        wc_wr   = 1'b0;
        wc_data = 8'h00;
        s_d.res_we = 1'b0;
        s_d.done   = 1'b0;
        s_d.io_we  = 1'b0;
        s_d.io_rd  = 1'b0;
        case (s_q.st)
            BAU_ST_IDLE: begin
                s_d.busy = 1'b0;
                if (op_valid) begin
                    case (op)
                        BAU_OP_ADD, BAU_OP_ADC: begin
                            cin  = (op == BAU_OP_ADC) & flags_in[BAU_FLAG_C];
                            sum  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
                            hsum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
                            r    = sum[7:0];
                            s_d.flags[BAU_FLAG_C] = sum[8];
                            s_d.flags[BAU_FLAG_H] = hsum[4];
                            s_d.flags[BAU_FLAG_V] = (a[7] == b[7]) && (r[7] != a[7]);
                            s_d.flags[BAU_FLAG_N] = r[7];
                            s_d.flags[BAU_FLAG_Z] = (r == 8'h00);
                            s_d.res = r;
                            s_d.res_we = 1'b1;
                            s_d.res_hi = 1'b0;
                            s_d.done = 1'b1;
                        end
                        BAU_OP_SUB, BAU_OP_SUBC: begin
                            cin  = (op == BAU_OP_SUBC) & flags_in[BAU_FLAG_C];
                            sum  = {1'b0, a} - {1'b0, b} - {8'h00, cin};
                            hsum = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
                            r    = sum[7:0];
                            s_d.flags[BAU_FLAG_C] = sum[8];
                            s_d.flags[BAU_FLAG_H] = hsum[4];
                            s_d.flags[BAU_FLAG_V] = (a[7] != b[7]) && (r[7] != a[7]);
                            s_d.flags[BAU_FLAG_N] = r[7];
                            s_d.flags[BAU_FLAG_Z] = (r == 8'h00);
                            s_d.res = r;
                            s_d.res_we = 1'b1;
                            s_d.res_hi = 1'b0;
                            s_d.done = 1'b1;
                        end
                        BAU_OP_AND, BAU_OP_OR: begin
                            r = (op == BAU_OP_AND) ? (a & b) : (a | b);
                            // carry and half-carry kept
                            s_d.flags[BAU_FLAG_V] = 1'b0;
                            s_d.flags[BAU_FLAG_N] = r[7];
                            s_d.flags[BAU_FLAG_Z] = (r == 8'h00);
                            s_d.res = r;
                            s_d.res_we = 1'b1;
                            s_d.res_hi = 1'b0;
                            s_d.done = 1'b1;
                        end
                        BAU_OP_ADDW, BAU_OP_SUBW: begin
                            // whole word computed now, bytes written over two clocks
                            if (op == BAU_OP_ADDW) begin
                                w = {1'b0, p} + {9'h000, immediate_constant};
                                s_d.flags[BAU_FLAG_V] = ~p[15] & w[15];
                            end else begin
                                w = {1'b0, p} - {9'h000, immediate_constant};
                                s_d.flags[BAU_FLAG_V] = p[15] & ~w[15];
                            end
                            s_d.flags[BAU_FLAG_C] = w[16];
                            s_d.flags[BAU_FLAG_N] = w[15];
                            s_d.flags[BAU_FLAG_S] = w[15] ^ s_d.flags[BAU_FLAG_V];
                            s_d.flags[BAU_FLAG_Z] = (w[15:0] == 16'h0000);
                            s_d.res = w[7:0];
                            s_d.hi_byte = w[15:8];
                            s_d.res_we = 1'b1;
                            s_d.res_hi = 1'b0;
                            s_d.busy = 1'b1;
                            s_d.st = BAU_ST_WORD2;
                        end
                        BAU_OP_SETB, BAU_OP_CLRB: begin
                            if (io_addr > BAU_IO_BIT_MAX) begin
                                err_d = 1'b1;
                                s_d.done = 1'b1;
                            end else begin
                                s_d.io_addr = io_addr[4:0];
                                s_d.io_bit  = io_bit;
                                s_d.io_set  = (op == BAU_OP_SETB);
                                s_d.io_rd   = 1'b1;
                                s_d.busy    = 1'b1;
                                s_d.st      = BAU_ST_IOWR;
                            end
                        end
                        default: begin
                            s_d.done = 1'b0;
                        end
                    endcase
                end
            end
            BAU_ST_WORD2: begin
                s_d.res = s_q.hi_byte;
                s_d.res_we = 1'b1;
                s_d.res_hi = 1'b1;
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.st = BAU_ST_IDLE;
            end
            BAU_ST_IOWR: begin
                // all bits written back, so set flags are cleared too, except the bit a clear op writes as zero
                // address 0 is read from our own flag register; the modified byte still goes out to the outside space on io_we
                if (s_q.io_addr == 5'h00) begin
                    m = wc_flags;
                end else begin
                    m = io_rdata;
                end
                m[s_q.io_bit] = s_q.io_set;
                s_d.io_wdata = m;
                s_d.io_we = 1'b1;
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.st = BAU_ST_IDLE;
                if (s_q.io_addr == 5'h00) begin
                    wc_wr   = 1'b1;
                    wc_data = m;
                end
            end
            default: begin
                s_d.st = BAU_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q   <= '0;
            err_q <= 1'b0;
        end else begin
            s_q   <= s_d;
            err_q <= err_d;
        end
    end

    assign result        = s_q.res;
    assign result_we     = s_q.res_we;
    assign result_high   = s_q.res_hi;
    assign flags_out     = s_q.flags;
    assign busy          = s_q.busy;
    assign done          = s_q.done;
    assign io_rd         = s_q.io_rd;
    assign io_we         = s_q.io_we;
    assign io_wr_addr    = s_q.io_addr;
    assign io_wdata      = s_q.io_wdata;
    assign io_addr_error = err_q;
endmodule : bau_alu

// ==== design/bau_pkg.sv ====
// constants and types for the byte arithmetic/logic datapath
// Function
// - add registers, optional carry, five flags, one clock
// - word add immediate to pair, two clocks
// - subtract registers, optional borrow, one clock
// - subtract immediate, one clock, five flags
// - subtract immediate with borrow, one clock
// - word subtract immediate from pair, two clocks
// - and/or one clock, carry and half-carry kept
// - writing one clears flag, zero keeps
// - io bit ops read-modify-write whole register
// - io bit ops reach only lowest range
package bau_pkg;
    typedef enum logic [3:0] {
        BAU_OP_NONE  = 4'h0,
        BAU_OP_ADD   = 4'h1,
        BAU_OP_ADC   = 4'h2,
        BAU_OP_SUB   = 4'h3,
        BAU_OP_SUBC  = 4'h4,
        BAU_OP_AND   = 4'h5,
        BAU_OP_OR    = 4'h6,
        BAU_OP_ADDW  = 4'h7,
        BAU_OP_SUBW  = 4'h8,
        BAU_OP_SETB  = 4'h9,
        BAU_OP_CLRB  = 4'hA
    } bau_op_t;

    // gray codes along idle -> word second half / io write
    typedef enum logic [1:0] {
        BAU_ST_IDLE  = 2'h0,
        BAU_ST_WORD2 = 2'h1,
        BAU_ST_IOWR  = 2'h2
    } bau_state_t;

    localparam int         BAU_W          = 8;
    localparam int         BAU_IO_AW      = 6;
    localparam int         BAU_BIT_AW     = 5;
    localparam logic [5:0] BAU_IO_BIT_MAX = 6'h1F;
    localparam int         BAU_FLAG_C     = 0;
    localparam int         BAU_FLAG_Z     = 1;
    localparam int         BAU_FLAG_N     = 2;
    localparam int         BAU_FLAG_V     = 3;
    localparam int         BAU_FLAG_S     = 4;
    localparam int         BAU_FLAG_H     = 5;
    localparam logic [5:0] BAU_FLAGS_RST  = 6'h00;
    localparam logic [7:0] BAU_BYTE_RST   = 8'h00;

    typedef struct packed {
        bau_state_t  st;
        logic [7:0]  res;
        logic [5:0]  flags;
        logic        res_we;
        logic        res_hi;
        logic        busy;
        logic        done;
        logic [7:0]  hi_byte;
        logic        hi_carry;
        logic        lo_zero;
        logic        io_rd;
        logic        io_we;
        logic [4:0]  io_addr;
        logic [7:0]  io_wdata;
        logic [2:0]  io_bit;
        logic        io_set;
    } bau_state_s_t;
endpackage : bau_pkg

// ==== design/bau_flag_reg.sv ====
`timescale 1ns/1ps
// holds a register of flags with write-one-to-clear and hardware set
module bau_flag_reg (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [7:0]       hw_set,
    input  wire logic             wr_en,
    input  wire logic [7:0]       wr_data,
    output logic      [7:0]       flags_q
);
    import bau_pkg::*;
    logic [7:0] flags_d;

    always_comb begin
        flags_d = flags_q;
        if (wr_en) begin
            flags_d = flags_d & ~wr_data;
        end
        flags_d = flags_d | hw_set; // set wins over clear
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_q <= BAU_BYTE_RST;
        end else begin
            flags_q <= flags_d;
        end
    end
endmodule : bau_flag_reg

// ==== verif/bau_alu_props.sv ====
// assertion checker for the byte arithmetic/logic datapath
`timescale 1ns/1ps
module bau_alu_props
    import bau_pkg::*;
(
    input wire logic             clk,
    input wire logic             arst_n,
    input wire bau_pkg::bau_op_t op,
    input wire logic             op_valid,
    input wire logic [7:0]       dest_operand_reg,
    input wire logic [7:0]       source_operand_reg,
    input wire logic             use_immediate,
    input wire logic [7:0]       immediate_constant,
    input wire logic [5:0]       io_addr,
    input wire logic [7:0]       result,
    input wire logic             result_we,
    input wire logic             result_high,
    input wire logic [5:0]       flags_out,
    input wire logic             busy,
    input wire logic             done,
    input wire logic             io_rd,
    input wire logic             io_we,
    input wire logic             io_addr_error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic go, word, bit_op;
    assign go     = op_valid && !busy;
    assign word   = go && (op == BAU_OP_ADDW || op == BAU_OP_SUBW);
    assign bit_op = go && (op == BAU_OP_SETB || op == BAU_OP_CLRB);

    a_byte_one_clk : assert property (go && op >= BAU_OP_ADD && op <= BAU_OP_OR
        |=> result_we && done && !busy) else $error("byte op not done in one clock");
    a_word_two_clk : assert property (word |=> result_we && !result_high && busy
        ##1 result_we && result_high && done && !busy) else $error("word op sequence wrong");
    a_logic_keep_ch : assert property (go && (op == BAU_OP_AND || op == BAU_OP_OR)
        |=> flags_out[BAU_FLAG_C] == $past(flags_out[BAU_FLAG_C])
        && flags_out[BAU_FLAG_H] == $past(flags_out[BAU_FLAG_H]) && !flags_out[BAU_FLAG_V])
        else $error("logic op disturbed carry or half-carry");
    a_sub_borrow : assert property (go && op == BAU_OP_SUB && !use_immediate
        |=> result == $past(dest_operand_reg) - $past(source_operand_reg)
        && flags_out[BAU_FLAG_C] == ($past(dest_operand_reg) < $past(source_operand_reg)))
        else $error("register subtract wrong");
    a_sub_imm : assert property (go && op == BAU_OP_SUB && use_immediate
        |=> result == $past(dest_operand_reg) - $past(immediate_constant))
        else $error("immediate subtract wrong");
    a_io_rmw_seq : assert property (bit_op && io_addr <= BAU_IO_BIT_MAX
        |=> io_rd && !io_we ##1 io_we && done && !io_rd) else $error("bit op not read then write");
    a_io_range : assert property (bit_op && io_addr > BAU_IO_BIT_MAX
        |=> io_addr_error && done && !io_rd && !io_we ##1 !io_we) else $error("high io address used");
    a_result_hold : assert property ($changed(result) |-> result_we)
        else $error("result moved without write strobe");

    c_word  : cover property (word ##2 done);
    c_bit   : cover property (bit_op ##2 io_we);
    c_range : cover property (io_addr_error);
endmodule : bau_alu_props

bind bau_alu bau_alu_props u_props (.clk, .arst_n, .op, .op_valid, .dest_operand_reg,
    .source_operand_reg, .use_immediate, .immediate_constant, .io_addr, .result, .result_we,
    .result_high, .flags_out, .busy, .done, .io_rd, .io_we, .io_addr_error);

// ==== verif/bau_io_model.sv ====
// behavioural io register space seen by the bit operations
`timescale 1ns/1ps
module bau_io_model (
    input  wire logic       clk,
    input  wire logic [5:0] io_addr,
    input  wire logic       io_we,
    input  wire logic [4:0] io_wr_addr,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata
);
    logic [7:0] mem_q [32];
    initial foreach (mem_q[i]) mem_q[i] = 8'h81;
    // nothing answers above the low range; inverse exposes a stale read
    assign io_rdata = (io_addr > 6'h1F) ? ~mem_q[io_addr[4:0]] : mem_q[io_addr[4:0]];
    always @(posedge clk) if (io_we) mem_q[io_wr_addr] <= io_wdata;
endmodule : bau_io_model

// ==== verif/testbench.sv ====
// self-checking bench for the byte arithmetic/logic datapath
`timescale 1ns/1ps
module testbench;
    import bau_pkg::*;
    bau_op_t    op;
    logic       clk, arst_n, op_valid, use_immediate, result_we, result_high, busy, done;
    logic       io_rd, io_we, io_addr_error;
    logic [7:0] dest_operand_reg, source_operand_reg, immediate_constant, pair_high_reg;
    logic [7:0] pair_low_reg, io_rdata, flag_hw_set, result, io_wdata, wc_flags, lo_seen;
    logic [5:0] flags_in, flags_out, io_addr, exp_f;
    logic [4:0] io_wr_addr;
    logic [2:0] io_bit;
    int         err_count = 0, n_compared = 0, cyc = 0;

    bau_alu dut (.clk, .arst_n, .op, .op_valid, .dest_operand_reg, .source_operand_reg,
        .use_immediate, .immediate_constant, .pair_high_reg, .pair_low_reg, .flags_in, .io_addr,
        .io_bit, .io_rdata, .flag_hw_set, .result, .result_we, .result_high, .flags_out, .busy,
        .done, .io_rd, .io_we, .io_wr_addr, .io_wdata, .io_addr_error, .wc_flags);
    bau_io_model u_io (.clk, .io_addr, .io_we, .io_wr_addr, .io_wdata, .io_rdata);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // tests take under a hundred cycles; a hang stops here at cycle 2000
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            conclude();
        end
    end

    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // one request, then wait for done; low byte of a word result is caught on the way
    task automatic start(bau_op_t o, logic [7:0] d, s, k, logic ui);
        int n;
        n = 0;
        @(posedge clk);
        op <= o;
        op_valid <= 1'b1;
        dest_operand_reg <= d;
        pair_high_reg <= d;
        source_operand_reg <= s;
        pair_low_reg <= s;
        immediate_constant <= k;
        use_immediate <= ui;
        flags_in <= exp_f;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        while (done !== 1'b1 && n < 4) begin
            if (result_we === 1'b1 && result_high === 1'b0) lo_seen = result;
            @(posedge clk);
            #1;
            n++;
        end
        chk("done", done, 16'h0001);
    endtask : start

    task automatic bt(bau_op_t o, logic [7:0] a, logic [7:0] b, logic ui);
        logic [8:0] r;
        logic [4:0] h;
        logic       c;
        // source gets the inverse under immediate so a wrong operand select shows
        start(o, a, ui ? ~b : b, b, ui);
        c = (o == BAU_OP_ADC || o == BAU_OP_SUBC) ? exp_f[BAU_FLAG_C] : 1'b0;
        if (o == BAU_OP_ADD || o == BAU_OP_ADC) begin
            r = a + b + c;
            h = a[3:0] + b[3:0] + c;
            exp_f[BAU_FLAG_V] = a[7] == b[7] && r[7] != a[7];
        end else begin
            r = a - b - c;
            h = a[3:0] - b[3:0] - c;
            exp_f[BAU_FLAG_V] = a[7] != b[7] && r[7] != a[7];
        end
        if (o == BAU_OP_AND || o == BAU_OP_OR) begin
            r = {1'b0, (o == BAU_OP_AND) ? (a & b) : (a | b)};
            exp_f[BAU_FLAG_V] = 1'b0;
        end else begin
            exp_f[BAU_FLAG_C] = r[8];
            exp_f[BAU_FLAG_H] = h[4];
        end
        exp_f[BAU_FLAG_Z] = r[7:0] == 8'h00;
        exp_f[BAU_FLAG_N] = r[7];
        chk("result", result, r[7:0]);
        chk("flags", flags_out, exp_f);
    endtask : bt

    task automatic wt(bau_op_t o, logic [15:0] v, logic [7:0] k);
        logic [16:0] w;
        logic        ov;
        start(o, v[15:8], v[7:0], k, 1'b1);
        w = (o == BAU_OP_ADDW) ? v + k : v - k;
        ov = (o == BAU_OP_ADDW) ? (!v[15] && w[15]) : (v[15] && !w[15]);
        exp_f[4:0] = {w[15] ^ ov, ov, w[15], w[15:0] == 16'h0000, w[16]};
        chk("word", {result, lo_seen}, w[15:0]);
        chk("word_flags", flags_out, exp_f);
    endtask : wt

    task automatic iot(bau_op_t o, logic [5:0] a, logic [2:0] b);
        @(posedge clk);
        io_addr <= a;
        io_bit <= b;
        start(o, 8'h00, 8'h00, 8'h00, 1'b0);
    endtask : iot

    initial begin
        {op_valid, use_immediate, dest_operand_reg, source_operand_reg} = '0;
        {immediate_constant, pair_high_reg, pair_low_reg, flags_in, io_addr, io_bit} = '0;
        op = BAU_OP_NONE;
        flag_hw_set = 8'h00;
        exp_f = BAU_FLAGS_RST;
        arst_n = 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk("reset_flags", flags_out, BAU_FLAGS_RST);
        bt(BAU_OP_ADD, 8'hF0, 8'h20, 1'b0);
        bt(BAU_OP_ADC, 8'h7F, 8'h00, 1'b0);
        bt(BAU_OP_SUB, 8'h80, 8'h01, 1'b1);
        bt(BAU_OP_SUBC, 8'h00, 8'hFF, 1'b1);
        bt(BAU_OP_SUBC, 8'h50, 8'h10, 1'b0);
        bt(BAU_OP_SUB, 8'h10, 8'h20, 1'b0);
        bt(BAU_OP_AND, 8'hF0, 8'h0F, 1'b0);
        bt(BAU_OP_OR, 8'h80, 8'h01, 1'b1);
        $display("byte tests done");
        wt(BAU_OP_ADDW, 16'h7FFF, 8'h01);
        wt(BAU_OP_ADDW, 16'hFFFF, 8'h01);
        wt(BAU_OP_SUBW, 16'h0000, 8'h01);
        $display("word tests done");
        // only implemented io addresses are written
        // the io space takes the write one edge after done
        iot(BAU_OP_SETB, 6'h05, 3'h3);
        @(posedge clk);
        #1;
        chk("set_bit", u_io.mem_q[5], 8'h89);
        iot(BAU_OP_CLRB, 6'h05, 3'h0);
        @(posedge clk);
        #1;
        chk("clear_bit", u_io.mem_q[5], 8'h88);
        iot(BAU_OP_SETB, 6'h20, 3'h1);
        chk("range_error", io_addr_error, 16'h0001);
        @(posedge clk);
        #1;
        chk("range_untouched", u_io.mem_q[0], 8'h81);
        @(posedge clk) flag_hw_set <= 8'h04;
        @(posedge clk) flag_hw_set <= 8'h00;
        #1;
        chk("flag_set", wc_flags, 8'h04);
        iot(BAU_OP_SETB, 6'h00, 3'h5);
        chk("flag_cleared", wc_flags, 8'h00);
        $display("io tests done");
        conclude();
    end
endmodule : testbench
